// file: src/usbocs_pkg.sv
// Types shared by the control and status section and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package usbocs_pkg;

  // One completed transaction as reported by the serial engine.
  typedef struct packed {
    logic valid;
    logic [3:0] endpoint;
    logic isTx;
    logic oddBank;
  } usbocs_xfer_t;

  // A received frame-start token with its frame number.
  typedef struct packed {
    logic valid;
    logic [10:0] frame;
  } usbocs_sof_t;

  // Controls driven towards the serial engine and transceiver.
  typedef struct packed {
    logic controllerEnable;
    logic sofGenEnable;
    logic sofGenPulse;
    logic busResetDrive;
    logic resumeDrive;
    logic resumeEopAppend;
    logic pingpongReset;
    logic hostLogicReset;
    logic packetProcessingDisable;
    logic lowSpeedSelect;
    logic [6:0] deviceAddress;
    logic tokenStart;
    logic [7:0] tokenCommand;
  } usbocs_ctrl_t;

  typedef struct packed {
    logic [3:0] endpoint;
    logic isTx;
    logic oddBank;
  } usbocs_entry_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ = 3'b100
  } usbocs_bus_state_t;

endpackage

// file: src/usbocs_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// control and status section. Included by the design file, the bench and the checker.
// Function
// RULE_01 - Status register heads a four-entry queue.
// RULE_02 - Status valid while flag set; clear pops.
// RULE_03 - Status bits 7-4 hold endpoint number.
// RULE_04 - Status bit 3 marks transmit, zero receive.
// RULE_05 - Status bit 2 marks odd bank; 1-0 zero.
// RULE_06 - Control bit 7 shows live J state.
// RULE_07 - Control bit 6 shows live single-ended zero.
// RULE_08 - Device bit 5 disables packets; setup sets.
// RULE_09 - Host bit 5 reads token in progress.
// RULE_10 - Host software waits token idle before commanding.
// RULE_11 - Host bit 4 drives bus reset signalling.
// RULE_12 - Bit 3 enables host; toggle resets host.
// RULE_13 - Software holds resume 10 or 25 ms.
// RULE_14 - Bit 2 drives resume; host appends EOP.
// RULE_15 - Bit 1 forces pointers to even bank.
// RULE_16 - Device bit 0 enables the controller.
// RULE_17 - Host bit 0 sends frame start every 1 ms.
// RULE_18 - Address bit 7 selects low speed.
// RULE_19 - Address bits 6-0 hold device address.
// RULE_20 - Frame low byte loaded on received frame start.
// RULE_21 - Bits 31-8 ignore writes, read zero.
// RULE_22 - Frame high bits 2-0 loaded likewise.
// RULE_23 - Push per transaction; flag stays while entries.
`ifndef USBOCS_REGS_SVH
`define USBOCS_REGS_SVH

`define USBOCS_OFF_STAT 8'h00
`define USBOCS_OFF_CON 8'h04
`define USBOCS_OFF_ADDR 8'h08
`define USBOCS_OFF_FRAME_NUMBER_LOW_BYTE 8'h0C
`define USBOCS_OFF_FRAME_NUMBER_HIGH_BITS 8'h10
`define USBOCS_OFF_TRN 8'h14
`define USBOCS_OFF_TOK 8'h18

`define USBOCS_CON_JSTATE 7
`define USBOCS_CON_SE0 6
`define USBOCS_CON_PKTBUSY 5
`define USBOCS_CON_BUSRST 4
`define USBOCS_CON_HOST_CAPABILITY_ENABLE 3
`define USBOCS_CON_RESUME 2
`define USBOCS_CON_PPRST 1
`define USBOCS_CON_ENABLE 0
`define USBOCS_ADDR_LOWSPD 7
`define USBOCS_TRN_FLAG 0

`define USBOCS_CON_RST 8'h00
`define USBOCS_ADDR_RST 8'h00
`define USBOCS_FRM_RST 11'h000
`define USBOCS_TOK_RST 8'h00

`define USBOCS_SOF_PERIOD_MS 1
`define USBOCS_CLK_KHZ 250000
`define USBOCS_SOF_CYCLES (`USBOCS_SOF_PERIOD_MS * `USBOCS_CLK_KHZ)

`endif

// file: src/usbocs_top.sv
// Control and status section of a full-speed OTG controller with an
// AHB-Lite register slave. Assumes one clock, the serial engine on the
// side ports, and synchronous line-state inputs.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "usbocs_regs.svh"

module usbocs_top #(
  parameter int DEPTH = 4,
  parameter int SOF_CYCLES = `USBOCS_SOF_CYCLES
) (
  input wire logic clk, // 250 MHz clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  input wire usbocs_pkg::usbocs_xfer_t xferDone, // transaction completed
  input wire usbocs_pkg::usbocs_sof_t sofRcvd, // frame start received
  input wire logic setupRcvd, // SETUP token received pulse
  input wire logic tokenDone, // token command finished pulse
  input wire logic lineJState, // receiver sees J state
  input wire logic lineSe0, // single-ended zero on lines
  output usbocs_pkg::usbocs_ctrl_t ctrlOut, // controls to the engine
  output logic trnFlag // transaction complete flag
);
  import usbocs_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = $clog2(SOF_CYCLES + 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  usbocs_bus_state_t busState_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic addrPhase;
  logic wrEn;
  logic [7:0] wrByte;
  logic [31:0] rdMux;

  assign addrPhase = hsel & htrans[1] & hready;
  assign wrEn = (busState_ff == BUS_WRITE);
  assign wrByte = hwdata[7:0];

  // Reads take one wait state so they always see the effect of a write
  // that finished in the same cycle as the read's address phase.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busState_ff <= BUS_IDLE;
      addr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
    end else begin
      case (busState_ff)
        BUS_READ: begin
          busState_ff <= BUS_IDLE;
          hreadyout_ff <= 1'b1;
        end
        BUS_IDLE, BUS_WRITE: begin
          if (addrPhase) begin
            addr_ff <= haddr[7:0];
            busState_ff <= hwrite ? BUS_WRITE : BUS_READ;
            hreadyout_ff <= hwrite;
          end else begin
            busState_ff <= BUS_IDLE;
          end
        end
        default: begin
          busState_ff <= BUS_IDLE;
          hreadyout_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (busState_ff == BUS_READ) begin
      hrdata_ff <= rdMux;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Control and address registers
  // ----------------------------------------------------------------
  logic [7:0] con_ff;
  logic [7:0] addrReg_ff;
  logic packet_processing_disable_ff;
  logic conWr;
  logic hostMode;

  assign conWr = wrEn & hit(addr_ff, `USBOCS_OFF_CON);
  assign hostMode = con_ff[`USBOCS_CON_HOST_CAPABILITY_ENABLE];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      con_ff <= `USBOCS_CON_RST;
    end else if (conWr) begin
      con_ff <= {3'b000, wrByte[4:0]}; // RULE_21
    end
  end

  // Device-mode packet disable: a SETUP arrival wins over a clearing write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      packet_processing_disable_ff <= 1'b0;
    end else if (setupRcvd & ~hostMode) begin
      packet_processing_disable_ff <= 1'b1; // RULE_08
    end else if (conWr & ~hostMode) begin
      packet_processing_disable_ff <= wrByte[`USBOCS_CON_PKTBUSY]; // RULE_08
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrReg_ff <= `USBOCS_ADDR_RST;
    end else if (wrEn & hit(addr_ff, `USBOCS_OFF_ADDR)) begin
      addrReg_ff <= wrByte; // RULE_18 RULE_19
    end
  end

  // ----------------------------------------------------------------
  // Token command and busy indication
  // ----------------------------------------------------------------
  logic [7:0] tokCmd_ff;
  logic token_in_progress_ff;
  logic tokStart_ff;
  logic tokWr;
  logic hostToggle;

  // A command written while busy is dropped.
  assign tokWr = wrEn & hit(addr_ff, `USBOCS_OFF_TOK) & hostMode & ~token_in_progress_ff; // RULE_10
  assign hostToggle = conWr & (wrByte[`USBOCS_CON_HOST_CAPABILITY_ENABLE] != hostMode);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tokCmd_ff <= `USBOCS_TOK_RST;
      token_in_progress_ff <= 1'b0;
      tokStart_ff <= 1'b0;
    end else begin
      tokStart_ff <= tokWr;
      if (tokWr) begin
        tokCmd_ff <= wrByte;
      end
      if (hostToggle) begin
        token_in_progress_ff <= 1'b0; // RULE_12
      end else if (tokWr) begin
        token_in_progress_ff <= 1'b1; // RULE_09
      end else if (tokenDone) begin
        token_in_progress_ff <= 1'b0; // RULE_09
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame-start generation in host mode
  // ----------------------------------------------------------------
  logic [SW-1:0] sofCnt_ff;
  logic sofPulse_ff;
  logic sofRun;

  assign sofRun = hostMode & con_ff[`USBOCS_CON_ENABLE];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sofCnt_ff <= '0;
      sofPulse_ff <= 1'b0;
    end else if (!sofRun || hostToggle) begin
      sofCnt_ff <= '0; // RULE_12 RULE_17
      sofPulse_ff <= 1'b0;
    end else if (sofCnt_ff == SW'(SOF_CYCLES - 1)) begin
      sofCnt_ff <= '0;
      sofPulse_ff <= 1'b1; // RULE_17
    end else begin
      sofCnt_ff <= sofCnt_ff + SW'(1);
      sofPulse_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Frame number capture
  // ----------------------------------------------------------------
  logic [10:0] frame_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_ff <= `USBOCS_FRM_RST;
    end else if (sofRcvd.valid) begin
      frame_ff <= sofRcvd.frame; // RULE_20 RULE_22
    end
  end

  // ----------------------------------------------------------------
  // Transaction status queue
  // ----------------------------------------------------------------
  usbocs_entry_t queue_ff [DEPTH];
  logic [PW-1:0] rdPtr_ff;
  logic [PW-1:0] wrPtr_ff;
  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic trnFlag_ff;
  logic pop;
  logic push;

  // Software clears the flag by writing one; that advances the queue.
  assign pop = wrEn & hit(addr_ff, `USBOCS_OFF_TRN) & wrByte[`USBOCS_TRN_FLAG]
               & (count_ff != '0); // RULE_02
  // A completion arriving when the queue is full and not popping is lost.
  assign push = xferDone.valid & ((count_ff != CW'(DEPTH)) | pop); // RULE_23

  always_comb begin
    nxt_count = count_ff;
    if (push & ~pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop & ~push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        queue_ff[i] <= '0;
      end
      rdPtr_ff <= '0;
      wrPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        queue_ff[wrPtr_ff] <= {xferDone.endpoint, xferDone.isTx, xferDone.oddBank}; // RULE_01
        wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1); // RULE_02
      end
      count_ff <= nxt_count;
    end
  end

  // The flag stays set while unread entries remain; a push wins a clear.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trnFlag_ff <= 1'b0;
    end else begin
      trnFlag_ff <= (nxt_count != '0); // RULE_23
    end
  end

  assign trnFlag = trnFlag_ff;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  usbocs_entry_t head;
  logic [7:0] conRd;

  assign head = queue_ff[rdPtr_ff];

  always_comb begin
    conRd = {3'b000, con_ff[4:0]};
    conRd[`USBOCS_CON_JSTATE] = lineJState; // RULE_06
    conRd[`USBOCS_CON_SE0] = lineSe0; // RULE_07
    conRd[`USBOCS_CON_PKTBUSY] = hostMode ? token_in_progress_ff : packet_processing_disable_ff; // RULE_08 RULE_09
  end

  always_comb begin
    rdMux = 32'h00000000; // RULE_21
    case (addr_ff)
      `USBOCS_OFF_STAT: begin
        if (count_ff != '0) begin
          rdMux[7:0] = {head.endpoint, head.isTx, head.oddBank, 2'b00}; // RULE_03 RULE_04 RULE_05
        end
      end
      `USBOCS_OFF_CON: rdMux[7:0] = conRd;
      `USBOCS_OFF_ADDR: rdMux[7:0] = addrReg_ff;
      `USBOCS_OFF_FRAME_NUMBER_LOW_BYTE: rdMux[7:0] = frame_ff[7:0]; // RULE_20
      `USBOCS_OFF_FRAME_NUMBER_HIGH_BITS: rdMux[7:0] = {5'b00000, frame_ff[10:8]}; // RULE_22
      `USBOCS_OFF_TRN: rdMux[7:0] = {7'b0000000, trnFlag_ff};
      `USBOCS_OFF_TOK: rdMux[7:0] = tokCmd_ff;
      default: rdMux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  usbocs_ctrl_t ctrl_ff;
  logic resumeFall;

  assign resumeFall = conWr & con_ff[`USBOCS_CON_RESUME] & ~wrByte[`USBOCS_CON_RESUME];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff.controllerEnable <= ~hostMode & con_ff[`USBOCS_CON_ENABLE]; // RULE_16
      ctrl_ff.sofGenEnable <= sofRun; // RULE_17
      ctrl_ff.sofGenPulse <= sofPulse_ff; // RULE_17
      ctrl_ff.busResetDrive <= hostMode & con_ff[`USBOCS_CON_BUSRST]; // RULE_11
      ctrl_ff.resumeDrive <= con_ff[`USBOCS_CON_RESUME]; // RULE_14
      ctrl_ff.resumeEopAppend <= resumeFall & hostMode; // RULE_14
      ctrl_ff.pingpongReset <= con_ff[`USBOCS_CON_PPRST]; // RULE_15
      ctrl_ff.hostLogicReset <= hostToggle; // RULE_12
      ctrl_ff.packetProcessingDisable <= ~hostMode & packet_processing_disable_ff; // RULE_08
      ctrl_ff.lowSpeedSelect <= addrReg_ff[`USBOCS_ADDR_LOWSPD]; // RULE_18
      ctrl_ff.deviceAddress <= addrReg_ff[6:0]; // RULE_19
      ctrl_ff.tokenStart <= tokStart_ff;
      ctrl_ff.tokenCommand <= tokCmd_ff;
    end
  end

  assign ctrlOut = ctrl_ff;

endmodule

// file: testbench/tb.sv
// Self-checking bench for the control and status section.
// Assumes the package, header, design, checker and engine model compile first.
`timescale 1ns/100ps
`include "usbocs_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end

module tb;
  import usbocs_pkg::*;
  // ----
  // Bench
  // ----
  localparam int SOFC = 20;
  localparam int RESH = 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, trnFlag, setupRcvd, tokenDone, lineJState, lineSe0;
  usbocs_xfer_t xferDone;
  usbocs_sof_t sofRcvd;
  usbocs_ctrl_t ctrlOut;
  int num_errors = 0;
  int checks_done = 0;
  int hlrN = 0;
  int sofN = 0;
  int eopN = 0;
  int tokN = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    hlrN <= hlrN + int'(ctrlOut.hostLogicReset === 1'b1);
    sofN <= sofN + int'(ctrlOut.sofGenPulse === 1'b1);
    eopN <= eopN + int'(ctrlOut.resumeEopAppend === 1'b1);
    tokN <= tokN + int'(ctrlOut.tokenStart === 1'b1);
  end
  usbocs_top #(.DEPTH(4), .SOF_CYCLES(SOFC)) u_usbocs_top (.clk, .resetn, .hsel(1'b1),
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .xferDone, .sofRcvd, .setupRcvd, .tokenDone, .lineJState,
    .lineSe0, .ctrlOut, .trnFlag);
  usbocs_eng u_usbocs_eng (.clk, .ctrlOut, .xferDone, .sofRcvd, .setupRcvd, .tokenDone,
    .lineJState, .lineSe0);
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic t_regs();
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
    foreach (offs[i]) rdc(offs[i], 32'h0);
    `CHK(hresp, 1'b0)
  endtask
  task automatic t_addr();
    wr(`USBOCS_OFF_ADDR, 32'hFFFFFF85);
    rdc(`USBOCS_OFF_ADDR, 32'h85);
    `CHK(ctrlOut.lowSpeedSelect, 1'b1)
    `CHK(ctrlOut.deviceAddress, 7'h05)
    wr(`USBOCS_OFF_FRAME_NUMBER_LOW_BYTE, 32'hFF);
    rdc(`USBOCS_OFF_FRAME_NUMBER_LOW_BYTE, 32'h0);
  endtask
  task automatic t_queue();
    u_usbocs_eng.pushN(5);
    rdc(`USBOCS_OFF_TRN, 32'h1);
    for (int i = 0; i < 4; i++) begin
      `CHK(trnFlag, 1'b1)
      rdc(`USBOCS_OFF_STAT, {24'h0, 4'(i * 5), i[0], i[1], 2'b00});
      wr(`USBOCS_OFF_TRN, 32'h1);
    end
    `CHK(trnFlag, 1'b0)
    rdc(`USBOCS_OFF_STAT, 32'h0);
  endtask
  task automatic t_lines();
    for (int k = 3; k >= 0; k--) begin
      u_usbocs_eng.lines(k[1], k[0]);
      rdc(`USBOCS_OFF_CON, {24'h0, k[1], k[0], 6'h0});
    end
  endtask
  task automatic t_device();
    wr(`USBOCS_OFF_CON, 32'hFFFFFF01);
    `CHK(ctrlOut.controllerEnable, 1'b1)
    `CHK(ctrlOut.sofGenEnable, 1'b0)
    u_usbocs_eng.setup();
    repeat (2) @(posedge clk);
    rdc(`USBOCS_OFF_CON, 32'h21);
    `CHK(ctrlOut.packetProcessingDisable, 1'b1)
    wr(`USBOCS_OFF_CON, 32'h07);
    rdc(`USBOCS_OFF_CON, 32'h07);
    `CHK(ctrlOut.pingpongReset, 1'b1)
    `CHK(ctrlOut.resumeDrive, 1'b1)
    wr(`USBOCS_OFF_CON, 32'h0);
    `CHK(ctrlOut.resumeDrive, 1'b0)
    `CHK(eopN, 0)
    `CHK(ctrlOut.controllerEnable, 1'b0)
    `CHK(ctrlOut.pingpongReset, 1'b0)
  endtask
  task automatic t_host();
    int s0;
    int n;
    wr(`USBOCS_OFF_CON, 32'h08);
    `CHK(hlrN, 1)
    s0 = sofN;
    wr(`USBOCS_OFF_CON, 32'h19);
    `CHK(ctrlOut.busResetDrive, 1'b1)
    repeat (100) @(posedge clk);
    `CHK((sofN - s0) >= 4 && (sofN - s0) <= 5, 1'b1)
    `CHK(hlrN, 1)
    wr(`USBOCS_OFF_CON, 32'h09);
    `CHK(ctrlOut.busResetDrive, 1'b0)
    wr(`USBOCS_OFF_TOK, 32'h1A);
    rdc(`USBOCS_OFF_CON, 32'h29);
    wr(`USBOCS_OFF_TOK, 32'h93);
    `CHK(tokN, 1)
    `CHK(ctrlOut.tokenCommand, 8'h1A)
    rdc(`USBOCS_OFF_TOK, 32'h1A);
    n = 0;
    do begin
      bus(`USBOCS_OFF_CON, 1'b0, 32'h0);
      n++;
    end while (rd[5] !== 1'b0 && n < 40);
    `CHK(rd, 32'h09)
    wr(`USBOCS_OFF_TOK, 32'h93);
    `CHK(tokN, 2)
    wr(`USBOCS_OFF_CON, 32'h0D);
    `CHK(ctrlOut.resumeDrive, 1'b1)
    repeat (RESH) @(posedge clk);
    wr(`USBOCS_OFF_CON, 32'h09);
    `CHK(eopN, 1)
    u_usbocs_eng.sof(11'h5A3);
    repeat (2) @(posedge clk);
    rdc(`USBOCS_OFF_FRAME_NUMBER_LOW_BYTE, 32'hA3);
    rdc(`USBOCS_OFF_FRAME_NUMBER_HIGH_BITS, 32'h05);
    wr(`USBOCS_OFF_CON, 32'h0);
    `CHK(hlrN, 2)
  endtask
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_addr();
    t_queue();
    t_lines();
    t_device();
    t_host();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule

bind usbocs_top usbocs_asserts u_usbocs_asserts (.clk, .resetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .xferDone, .ctrlOut, .trnFlag);

// file: testbench/usbocs_asserts.sv
// Concurrent checks on the ports of the control and status section.
// Assumes one clock domain and the register offsets of the shared header.
`timescale 1ns/100ps
`include "usbocs_regs.svh"

module usbocs_asserts (
  input wire logic clk, // clock
  input wire logic resetn, // reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // slave ready
  input wire usbocs_pkg::usbocs_xfer_t xferDone, // completions
  input wire usbocs_pkg::usbocs_ctrl_t ctrlOut, // engine controls
  input wire logic trnFlag // complete flag
);
  import usbocs_pkg::*;
  // ----
  // Checks
  // ----
  wire logic take = hsel && htrans[1] && hready;
  wire logic wrTrn = take && hwrite && haddr[7:0] == `USBOCS_OFF_TRN;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rdTake; take && !hwrite; endsequence
  sequence statTake; take && !hwrite && haddr[7:0] == `USBOCS_OFF_STAT; endsequence
  sequence rdAns; !hreadyout ##1 hreadyout; endsequence
  read_wait_a: assert property (rdTake |=> rdAns)
    else $error("read wait state wrong");
  stat_low_a: assert property (statTake |-> ##2 hrdata[1:0] == 2'b00)
    else $error("status low bits not zero");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  flag_set_a: assert property (xferDone.valid |-> ##[1:2] trnFlag)
    else $error("flag not set after completion");
  flag_fall_a: assert property ($fell(trnFlag) |-> $past(wrTrn, 2) || $past(wrTrn, 3))
    else $error("flag fell without a pop");
  mode_excl_a: assert property (!(ctrlOut.controllerEnable && ctrlOut.sofGenEnable))
    else $error("device and host enables together");
  sof_space_a: assert property (ctrlOut.sofGenPulse |=> !ctrlOut.sofGenPulse [*8])
    else $error("frame starts too close");
  eop_after_a: assert property ($rose(ctrlOut.resumeEopAppend)
    |-> ctrlOut.resumeDrive ##1 !ctrlOut.resumeDrive)
    else $error("end of packet without resume end");
  busrst_host_a: assert property (ctrlOut.busResetDrive |-> !ctrlOut.controllerEnable)
    else $error("bus reset outside host mode");
  tok_pulse_a: assert property (ctrlOut.tokenStart |=> !ctrlOut.tokenStart)
    else $error("token start longer than a cycle");
endmodule

// file: testbench/usbocs_eng.sv
// Model of the serial engine and line side feeding the section.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps

module usbocs_eng #(
  parameter int DONE_DLY = 30
) (
  input wire logic clk, // clock
  input wire usbocs_pkg::usbocs_ctrl_t ctrlOut, // controls from section
  output usbocs_pkg::usbocs_xfer_t xferDone, // completions
  output usbocs_pkg::usbocs_sof_t sofRcvd, // received frame starts
  output logic setupRcvd, // setup token seen
  output logic tokenDone, // token finished
  output logic lineJState, // J state on lines
  output logic lineSe0 // single-ended zero
);
  import usbocs_pkg::*;
  // ----
  // Engine behaviour
  // ----
  int tokCnt = 0;
  initial begin
    xferDone = '0;
    sofRcvd = '0;
    setupRcvd = 1'b0;
    tokenDone = 1'b0;
    lineJState = 1'b0;
    lineSe0 = 1'b0;
  end
  // A token takes DONE_DLY cycles on the wire before it reports done.
  always @(posedge clk) begin
    tokenDone <= 1'b0;
    if (ctrlOut.tokenStart === 1'b1) begin
      tokCnt <= DONE_DLY;
    end else if (tokCnt == 1) begin
      tokenDone <= 1'b1;
      tokCnt <= 0;
    end else if (tokCnt > 0) begin
      tokCnt <= tokCnt - 1;
    end
  end
  task automatic pushN(input int n);
    for (int i = 0; i < n; i++) begin
      xferDone <= {1'b1, 4'(i * 5), i[0], i[1]};
      @(posedge clk);
    end
    xferDone <= '0;
  endtask
  task automatic sof(input logic [10:0] fr);
    sofRcvd <= {1'b1, fr};
    @(posedge clk);
    sofRcvd <= '0;
  endtask
  task automatic setup();
    setupRcvd <= 1'b1;
    @(posedge clk);
    setupRcvd <= 1'b0;
  endtask
  task automatic lines(input logic j, input logic s);
    lineJState <= j;
    lineSe0 <= s;
  endtask
endmodule
